/* design/bridge_pkg.sv */
// Package: register map, field layout and decode types for the bridge window
package bridge_pkg;

	// Register indices as printed; byte address is four times the index
	localparam logic [7:0]  IDX_WINDOW_TOP   = 8'h26;
	localparam logic [7:0]  IDX_BRIDGE_CTRL  = 8'h3E;
	localparam logic [7:0]  IDX_WINDOW_BASE  = 8'h24;
	localparam logic [7:0]  IDX_IO_WINDOW    = 8'h1C;
	localparam logic [7:0]  IDX_IRQ_STATUS   = 8'h40;
	localparam logic [7:0]  IDX_IRQ_MASK     = 8'h41;
	localparam logic [7:0]  IDX_ERR_STATE    = 8'h42;
	localparam logic [9:0]  ADDR_WINDOW_TOP  = {IDX_WINDOW_TOP, 2'b00};
	localparam logic [9:0]  ADDR_BRIDGE_CTRL = {IDX_BRIDGE_CTRL, 2'b00};
	localparam logic [9:0]  ADDR_WINDOW_BASE = {IDX_WINDOW_BASE, 2'b00};
	localparam logic [9:0]  ADDR_IO_WINDOW   = {IDX_IO_WINDOW, 2'b00};
	localparam logic [9:0]  ADDR_IRQ_STATUS  = {IDX_IRQ_STATUS, 2'b00};
	localparam logic [9:0]  ADDR_IRQ_MASK    = {IDX_IRQ_MASK, 2'b00};
	localparam logic [9:0]  ADDR_ERR_STATE   = {IDX_ERR_STATE, 2'b00};

	// Reset values
	localparam logic [11:0] TOP_RESET        = 12'h000;
	localparam logic [11:0] BASE_RESET       = 12'hFFF;
	localparam logic [7:0]  IO_BASE_RESET    = 8'hFF;
	localparam logic [7:0]  IO_TOP_RESET     = 8'h00;
	localparam logic [4:0]  CTRL_RESET       = 5'h00;

	// Bridge control bit positions
	localparam int          BC_PARITY        = 0;
	localparam int          BC_ERRFWD        = 1;
	localparam int          BC_LEGACY        = 2;
	localparam int          BC_VIDEO         = 3;

	// Address decode constants
	localparam logic [19:0] LOW_ZERO         = 20'h00000;
	localparam logic [19:0] LOW_ONES         = 20'hFFFFF;
	localparam logic [11:0] IO_LOW_ZERO      = 12'h000;
	localparam logic [11:0] IO_LOW_ONES      = 12'hFFF;
	localparam logic [1:0]  ISA_LOW_QUARTER  = 2'b00;
	localparam logic [31:0] ALL_ONES         = 32'hFFFFFFFF;
	localparam logic [31:0] VGA_MEM_LO       = 32'h000A0000;
	localparam logic [31:0] VGA_MEM_HI       = 32'h000BFFFF;
	localparam logic [15:0] VGA_IO_LO0       = 16'h03B0;
	localparam logic [15:0] VGA_IO_HI0       = 16'h03BB;
	localparam logic [15:0] VGA_IO_LO1       = 16'h03C0;
	localparam logic [15:0] VGA_IO_HI1       = 16'h03DF;
	localparam logic [2:0]  IRQ_EVENTS       = 3'h7;

	// Processor request and route answer
	typedef struct packed {
		logic        valid;
		logic        is_io;
		logic        write;
		logic [31:0] addr;
	} cpu_req_t;

	typedef struct packed {
		logic        valid;
		logic        to_secondary;
		logic        prefetch;
		logic        video;
	} route_t;

	// Events arriving from the secondary link
	typedef struct packed {
		logic serr_msg;
		logic parity_err;
		logic other_err;
		logic master_abort;
	} link_evt_t;

endpackage

/* design/bridge_window_ctrl.sv */
// Bridge prefetch window top, bridge control, routing and error forwarding
//
// Local design decision: register access over APB.
`timescale 1ns/1ps
`default_nettype none
//
// Summary of operation
// - Window top field bits 15:4, reset zero
// - Limit decode fills low bits with ones
// - Window top bits 3:0 read zero
// - Fast back-to-back bit reads zero
// - Secondary reset bit reads zero, no reset
// - Master abort: drop writes, reads return ones
// - Video enable routes VGA ranges to secondary
// - Legacy filter off: forward whole I/O window
// - Filter on: top 768 bytes of each 1 KB block go primary, except VGA ranges with video enable
// - Filter acts only inside I/O window
// - Error forward bit gates secondary SERR
// - Parity reported only with both enables
// - Other errors signalled regardless of parity bit
// - Base decode fills low bits with zeros

module bridge_window_ctrl
	import bridge_pkg::*;
(
	// Clock and reset
	input  wire logic       pclk,
	input  wire logic       presetn,
	// APB slave
	input  wire logic       psel,
	input  wire logic       penable,
	input  wire logic       pwrite,
	input  wire logic [9:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0] pstrb,
	output logic            pready,
	output logic [31:0]     prdata,
	output logic            pslverr,
	// Processor request, answered one cycle later
	input  wire cpu_req_t   cpu_req,
	output route_t          route,
	// Master abort read data for reads on the secondary link
	output logic [31:0]     abort_rdata,
	output logic            abort_drop,
	// Secondary link events, same clock domain
	input  wire link_evt_t  link_evt,
	// SERR message towards the primary link
	output logic            serr_primary,
	// Interrupt
	output logic            irq
);

	////////////////////////////////////////////////////////////////////////
	// Registers

	logic [11:0] prefetch_limit_field;
	logic [11:0] prefetch_base_field;
	logic [7:0]  io_window_base;
	logic [7:0]  io_window_top;
	logic        video_range_enable;
	logic        legacy_io_filter_enable;
	logic        error_forward_enable;
	logic        parity_report_enable;
	logic [2:0]  irq_status;
	logic [2:0]  irq_mask;
	logic        serr_seen;

	logic        wr_en;
	logic        addr_hit;
	logic [2:0]  evt_set;
	logic [31:0] next_prdata;

	// Access phase completes in the cycle it begins; no wait states
	assign wr_en = psel && penable && pwrite && pready;

	// Decode of mapped words
	always_comb begin
		case (paddr)
			ADDR_WINDOW_TOP, ADDR_BRIDGE_CTRL, ADDR_WINDOW_BASE,
			ADDR_IO_WINDOW, ADDR_IRQ_STATUS, ADDR_IRQ_MASK,
			ADDR_ERR_STATE: addr_hit = 1'b1;
			default:        addr_hit = 1'b0;
		endcase
	end

	// Ready rises on the setup cycle so the access phase ends at once
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel && !penable;
			pslverr <= psel && !penable && !addr_hit;
		end
	end

	// Window top and base; only 12 upper bits stored
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prefetch_limit_field <= TOP_RESET;
			prefetch_base_field  <= BASE_RESET;
		end else if (wr_en && addr_hit) begin
			if (paddr == ADDR_WINDOW_TOP && pstrb[0])
				prefetch_limit_field[3:0] <= pwdata[7:4];
			if (paddr == ADDR_WINDOW_TOP && pstrb[1])
				prefetch_limit_field[11:4] <= pwdata[15:8];
			if (paddr == ADDR_WINDOW_BASE && pstrb[0])
				prefetch_base_field[3:0] <= pwdata[7:4];
			if (paddr == ADDR_WINDOW_BASE && pstrb[1])
				prefetch_base_field[11:4] <= pwdata[15:8];
		end
	end

	// I/O window, 4 KB granularity upper bits
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			io_window_base <= IO_BASE_RESET;
			io_window_top  <= IO_TOP_RESET;
		end else if (wr_en && paddr == ADDR_IO_WINDOW) begin
			if (pstrb[0])
				io_window_base <= pwdata[7:0];
			if (pstrb[1])
				io_window_top <= pwdata[15:8];
		end
	end

	// Bridge control; bits 7:4 are not stored and ignore writes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			video_range_enable      <= CTRL_RESET[BC_VIDEO];
			legacy_io_filter_enable <= CTRL_RESET[BC_LEGACY];
			error_forward_enable    <= CTRL_RESET[BC_ERRFWD];
			parity_report_enable    <= CTRL_RESET[BC_PARITY];
		end else if (wr_en && paddr == ADDR_BRIDGE_CTRL && pstrb[0]) begin
			video_range_enable      <= pwdata[BC_VIDEO];
			legacy_io_filter_enable <= pwdata[BC_LEGACY];
			error_forward_enable    <= pwdata[BC_ERRFWD];
			parity_report_enable    <= pwdata[BC_PARITY];
		end
	end

	// Read mux; hardwired fields read zero
	always_comb begin
		next_prdata = '0;
		case (paddr)
			ADDR_WINDOW_TOP:  next_prdata[15:4] = prefetch_limit_field;
			ADDR_WINDOW_BASE: next_prdata[15:4] = prefetch_base_field;
			ADDR_IO_WINDOW:   next_prdata[15:0] = {io_window_top,
				io_window_base};
			ADDR_BRIDGE_CTRL: next_prdata[3:0] = {video_range_enable,
				legacy_io_filter_enable, error_forward_enable,
				parity_report_enable};
			ADDR_IRQ_STATUS:  next_prdata[2:0] = irq_status;
			ADDR_IRQ_MASK:    next_prdata[2:0] = irq_mask;
			ADDR_ERR_STATE:   next_prdata[0] = serr_seen;
			default:          next_prdata = '0;
		endcase
	end

	// Data captured with ready so it is valid in the access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			prdata <= '0;
		else if (psel && !penable && !pwrite)
			prdata <= next_prdata;
	end

	////////////////////////////////////////////////////////////////////////
	// Address routing

	logic [31:0] pf_lo;
	logic [31:0] pf_hi;
	logic [15:0] io_lo;
	logic [15:0] io_hi;
	logic [15:0] io_addr;
	logic        in_prefetch;
	logic        in_io;
	logic        isa_alias;
	logic        vga_hit;

	assign pf_lo   = {prefetch_base_field, LOW_ZERO};
	assign pf_hi   = {prefetch_limit_field, LOW_ONES};
	assign io_lo   = {io_window_base[7:4], IO_LOW_ZERO};
	assign io_hi   = {io_window_top[7:4], IO_LOW_ONES};
	assign io_addr = cpu_req.addr[15:0];

	// Inclusive compare at both ends
	assign in_prefetch = !cpu_req.is_io && cpu_req.addr >= pf_lo
		&& cpu_req.addr <= pf_hi;
	assign in_io = cpu_req.is_io && io_addr >= io_lo && io_addr <= io_hi;
	// Upper three quarters of each 1 KB block belong to ISA aliases
	assign isa_alias = io_addr[9:8] != ISA_LOW_QUARTER;
	assign vga_hit = video_range_enable && (cpu_req.is_io
		? ((io_addr >= VGA_IO_LO0 && io_addr <= VGA_IO_HI0)
		|| (io_addr >= VGA_IO_LO1 && io_addr <= VGA_IO_HI1))
		: (cpu_req.addr >= VGA_MEM_LO && cpu_req.addr <= VGA_MEM_HI));

	// Filter only trims the window; outside it nothing changes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			route <= '0;
		end else begin
			route.valid        <= cpu_req.valid;
			route.prefetch     <= cpu_req.valid && in_prefetch;
			route.video        <= cpu_req.valid && vga_hit;
			route.to_secondary <= cpu_req.valid && (vga_hit || in_prefetch
				|| (in_io && !(legacy_io_filter_enable && isa_alias)));
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Master abort handling on the secondary link

	// Writes dropped, reads return all ones; mode is not selectable
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			abort_rdata <= '0;
			abort_drop  <= 1'b0;
		end else begin
			abort_drop  <= link_evt.master_abort;
			abort_rdata <= link_evt.master_abort ? ALL_ONES : '0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Error forwarding and interrupts

	// Parity needs both enables; other errors always forward
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			serr_primary <= 1'b0;
		else
			serr_primary <= (link_evt.serr_msg && error_forward_enable)
				|| (link_evt.parity_err && parity_report_enable
				&& error_forward_enable)
				|| link_evt.other_err;
	end

	assign evt_set = {link_evt.master_abort, link_evt.parity_err,
		link_evt.serr_msg};

	// Sticky status, write one to clear; a new event wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			irq_status <= '0;
		else if (wr_en && paddr == ADDR_IRQ_STATUS && pstrb[0])
			irq_status <= (irq_status & ~pwdata[2:0]) | evt_set;
		else
			irq_status <= irq_status | evt_set;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			irq_mask <= '0;
		else if (wr_en && paddr == ADDR_IRQ_MASK && pstrb[0])
			irq_mask <= pwdata[2:0] & IRQ_EVENTS;
	end

	// Record that an SERR was sent, cleared by writing one
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			serr_seen <= 1'b0;
		else if (serr_primary)
			serr_seen <= 1'b1;
		else if (wr_en && paddr == ADDR_ERR_STATE && pstrb[0] && pwdata[0])
			serr_seen <= 1'b0;
	end

	// Level output from a flop; one cycle behind status
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			irq <= 1'b0;
		else
			irq <= |(irq_status & irq_mask);
	end

endmodule
`default_nettype wire

/* sim/bridge_window_props.sv */
// Checker: port-level properties of the bridge window block
`timescale 1ns/1ps
`default_nettype none
module bridge_window_props
	import bridge_pkg::*;
(
	// Clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// APB
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [9:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic        pready,
	input wire logic [31:0] prdata,
	input wire logic        pslverr,
	// Routing and link
	input wire cpu_req_t    cpu_req,
	input wire route_t      route,
	input wire logic [31:0] abort_rdata,
	input wire logic        abort_drop,
	input wire link_evt_t   link_evt,
	input wire logic        serr_primary
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic [3:0]  ctl;
	logic [11:0] top;
	logic        wr_ok, rd_ok, exp_serr;
	assign wr_ok = psel && penable && pready && pwrite && !pslverr;
	assign rd_ok = psel && penable && pready && !pwrite && !pslverr;
	// Parity needs both enables, other errors need none
	assign exp_serr = link_evt.other_err
		| (link_evt.serr_msg & ctl[BC_ERRFWD])
		| (link_evt.parity_err & ctl[BC_ERRFWD] & ctl[BC_PARITY]);
	////////////////////////////////////////////////////////////////////////
	// Shadow of writable fields; full strobes assumed, as the bench drives
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctl <= 4'h0;
			top <= 12'h000;
		end else if (wr_ok && paddr == ADDR_BRIDGE_CTRL) begin
			ctl <= pwdata[3:0];
		end else if (wr_ok && paddr == ADDR_WINDOW_TOP) begin
			top <= pwdata[15:4];
		end
	end
	////////////////////////////////////////////////////////////////////////
	property p_top_rd;
		rd_ok && paddr == ADDR_WINDOW_TOP |-> prdata[15:0] == {top, 4'h0};
	endproperty
	a_top_rd: assert property (p_top_rd)
		else $error("window top readback wrong");
	property p_ctl_rd;
		rd_ok && paddr == ADDR_BRIDGE_CTRL |-> prdata[7:0] == {4'h0, ctl};
	endproperty
	a_ctl_rd: assert property (p_ctl_rd)
		else $error("bridge control readback wrong");
	property p_abort;
		link_evt.master_abort |=> abort_drop && abort_rdata == ALL_ONES;
	endproperty
	a_abort: assert property (p_abort)
		else $error("abort not answered with ones");
	property p_no_abort;
		!link_evt.master_abort |=> !abort_drop;
	endproperty
	a_no_abort: assert property (p_no_abort)
		else $error("drop without abort");
	property p_serr;
		1'b1 |=> serr_primary == $past(exp_serr);
	endproperty
	a_serr: assert property (p_serr)
		else $error("error forwarding wrong");
	property p_video;
		cpu_req.valid && !cpu_req.is_io && ctl[BC_VIDEO]
			&& cpu_req.addr inside {[VGA_MEM_LO:VGA_MEM_HI]}
			|=> route.to_secondary && route.video;
	endproperty
	a_video: assert property (p_video)
		else $error("video range not routed");
	property p_legacy;
		cpu_req.valid && cpu_req.is_io && ctl[BC_LEGACY]
			&& !ctl[BC_VIDEO] && cpu_req.addr[9:8] != 2'b00
			|=> !route.to_secondary;
	endproperty
	a_legacy: assert property (p_legacy)
		else $error("legacy range forwarded");
	property p_lat;
		1'b1 |=> route.valid == $past(cpu_req.valid);
	endproperty
	a_lat: assert property (p_lat)
		else $error("route answer latency wrong");
endmodule
bind bridge_window_ctrl bridge_window_props u_props (.pclk(pclk),
	.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
	.pslverr(pslverr), .cpu_req(cpu_req), .route(route),
	.abort_rdata(abort_rdata), .abort_drop(abort_drop),
	.link_evt(link_evt), .serr_primary(serr_primary));
`default_nettype wire

/* sim/link_partner.sv */
// Far-side model: secondary link event source
`timescale 1ns/1ps
`default_nettype none
module link_partner
	import bridge_pkg::*;
(
	// Clock
	input wire logic      pclk,
	// Events towards the bridge
	output var link_evt_t link_evt
);
	initial link_evt = '0;
	// One-cycle pulse launched just after an edge
	task automatic pulse(input link_evt_t e);
		@(posedge pclk);
		link_evt <= e;
		@(posedge pclk);
		link_evt <= '0;
	endtask
endmodule
`default_nettype wire

/* sim/tb_top.sv */
// Testbench: registers, routing, error forwarding and interrupt
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import bridge_pkg::*;
	logic        pclk = 1'b0, presetn = 1'b0;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [9:0]  paddr = '0;
	logic [31:0] pwdata = '0, prdata, rdata, abort_rdata;
	cpu_req_t    cpu_req = '0;
	route_t      route;
	link_evt_t   link_evt;
	logic        pready, pslverr, err, abort_drop, serr_primary, irq;
	int          fail_count = 0, tests_run = 0;

	always #12.5 pclk = ~pclk;

	link_partner far (.pclk(pclk), .link_evt(link_evt));
	bridge_window_ctrl uut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(4'hF), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.cpu_req(cpu_req), .route(route), .abort_rdata(abort_rdata),
		.abort_drop(abort_drop), .link_evt(link_evt),
		.serr_primary(serr_primary), .irq(irq));
	////////////////////////////////////////////////////////////////////////
	task automatic end_sim();
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input string s, input logic [31:0] e, g);
		tests_run++;
		if (g !== e) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", s, e, g);
		end
	endtask
	// APB transfer; request held until pready is seen at an edge
	task automatic apb(input logic w, input logic [9:0] a, input logic [31:0] d);
		int n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		rdata = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			fail_count++;
			end_sim();
		end
	endtask
	task automatic wr(input logic [9:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rd(input string s, input logic [9:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(s, e, rdata);
	endtask
	// Route is looked at in the one cycle it stands
	task automatic req(input logic io, input logic [31:0] a, input route_t e);
		@(posedge pclk);
		cpu_req <= '{1'b1, io, 1'b0, a};
		@(posedge pclk);
		cpu_req.valid <= 1'b0;
		@(negedge pclk);
		chk("route", {28'h0, e}, {28'h0, route});
	endtask
	task automatic ev(input link_evt_t e, input logic s);
		far.pulse(e);
		@(negedge pclk);
		chk("serr", {31'h0, s}, {31'h0, serr_primary});
		chk("abort", e.master_abort ? ALL_ONES : 32'h0, abort_rdata);
		chk("drop", {31'h0, e.master_abort}, {31'h0, abort_drop});
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		rd("top_rst", ADDR_WINDOW_TOP, 32'h0);
		rd("ctl_rst", ADDR_BRIDGE_CTRL, 32'h0);
		wr(ADDR_WINDOW_TOP, 32'hFFFF);
		rd("top_rw", ADDR_WINDOW_TOP, 32'hFFF0);
		wr(ADDR_BRIDGE_CTRL, 32'hFF);
		rd("ctl_ro", ADDR_BRIDGE_CTRL, 32'h0F);
		apb(1'b0, 10'h3FC, 32'h0);
		chk("slverr", 32'h1, {31'h0, err});
		wr(ADDR_WINDOW_BASE, 32'h1000);
		wr(ADDR_WINDOW_TOP, 32'h1FF0);
		req(1'b0, 32'h0FFFFFFF, 4'b1000);
		req(1'b0, 32'h10000000, 4'b1110);
		req(1'b0, 32'h1FFFFFFF, 4'b1110);
		req(1'b0, 32'h20000000, 4'b1000);
		req(1'b0, 32'h000A0000, 4'b1101);
		ev(4'b0100, 1'b1);
		ev(4'b1000, 1'b1);
		ev(4'b0001, 1'b0);
		wr(ADDR_BRIDGE_CTRL, 32'h1);
		ev(4'b0100, 1'b0);
		ev(4'b1000, 1'b0);
		ev(4'b0010, 1'b1);
		wr(ADDR_BRIDGE_CTRL, 32'h2);
		ev(4'b0100, 1'b0);
		ev(4'b1000, 1'b1);
		wr(ADDR_IO_WINDOW, 32'h1000);
		wr(ADDR_BRIDGE_CTRL, 32'h4);
		req(1'b1, 32'h0010, 4'b1100);
		req(1'b1, 32'h0100, 4'b1000);
		req(1'b1, 32'h3100, 4'b1000);
		wr(ADDR_BRIDGE_CTRL, 32'h0);
		req(1'b1, 32'h0100, 4'b1100);
		req(1'b0, 32'h000A0000, 4'b1000);
		// Interrupt: masked, unmasked, then cleared by writing one
		chk("irq_off", 32'h0, {31'h0, irq});
		rd("status", ADDR_IRQ_STATUS, 32'h7);
		wr(ADDR_IRQ_MASK, 32'h4);
		repeat (2) @(negedge pclk);
		chk("irq_on", 32'h1, {31'h0, irq});
		wr(ADDR_IRQ_STATUS, 32'h4);
		repeat (2) @(negedge pclk);
		chk("irq_clr", 32'h0, {31'h0, irq});
		rd("status_clr", ADDR_IRQ_STATUS, 32'h3);
		rd("serr_seen", ADDR_ERR_STATE, 32'h1);
		wr(ADDR_ERR_STATE, 32'h1);
		rd("serr_clr", ADDR_ERR_STATE, 32'h0);
		end_sim();
	end
endmodule
`default_nettype wire
